//--- byte_op_pkg.sv
// constants for the byte-oriented file-register decode and execute block
package byte_op_pkg;
    localparam int INSTR_WIDTH = 14;
    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 7;
    localparam int OPC_MSB = 11;
    localparam int OPC_LSB = 8;
    localparam int DEST_POS = 7;
    localparam int CLASS_MSB = 13;
    localparam int CLASS_LSB = 12;
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [3:0] OPC_DECREMENT = 4'h3;
    localparam logic [3:0] OPC_COMPLEMENT = 4'h9;
    localparam logic [3:0] OPC_DEC_SKIP = 4'hB;
    localparam logic [3:0] OPC_OR_WORKING = 4'h4;
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic DEST_WORKING = 1'b0;
    typedef enum logic [2:0] {
        NO_OP_SEL,
        DECREMENT_FILE_OP,
        COMPLEMENT_FILE_OP,
        DECREMENT_SKIP_ZERO_OP,
        OR_WORKING_WITH_FILE_OP
    } op_sel_t;
endpackage

//--- byte_op_decode_execute.sv
// decode and execute of four byte-oriented file-register instructions
`timescale 1ns/1ns

// Behaviour
// - 7-bit file address, one destination bit
// - decrement subtracts one, sets zero flag
// - complement inverts all bits, sets zero
// - decrement-and-skip subtracts one, tests zero
// - destination 0 writes working register only
// - destination 1 writes back file register
// - zero decrement-and-skip result discards fetched next instruction
// - discarded slot becomes a no-op cycle
// - skip uses zero only, flags untouched
// - or combines working and file, sets zero
// - port reads take pin levels, not latch
module byte_op_decode_execute #(
    parameter int ADDR_WIDTH = byte_op_pkg::ADDR_WIDTH,
    parameter int DATA_WIDTH = byte_op_pkg::DATA_WIDTH
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic instr_valid_in,
    input wire logic [byte_op_pkg::INSTR_WIDTH-1:0] instr_in,
    input wire logic [DATA_WIDTH-1:0] file_data_in,
    input wire logic file_is_port_in,
    input wire logic [DATA_WIDTH-1:0] port_pins_in,
    output logic [ADDR_WIDTH-1:0] file_addr_out,
    output logic [DATA_WIDTH-1:0] file_wdata_out,
    output logic file_we_out,
    output logic [DATA_WIDTH-1:0] working_out,
    output logic zero_flag_out,
    output logic flush_next_out,
    output logic nop_cycle_out
);

    // widths are fixed by the instruction word layout, so other values are refused at elaboration
    if (ADDR_WIDTH != byte_op_pkg::ADDR_WIDTH || DATA_WIDTH != byte_op_pkg::DATA_WIDTH) begin : g_width_check
        $error("byte_op_decode_execute: unsupported width");
    end

    // decode of the fields used by several places
    function automatic byte_op_pkg::op_sel_t decode_op(input logic [byte_op_pkg::INSTR_WIDTH-1:0] w);
        byte_op_pkg::op_sel_t s;
        s = byte_op_pkg::NO_OP_SEL;
        if (w[byte_op_pkg::CLASS_MSB:byte_op_pkg::CLASS_LSB] == byte_op_pkg::CLASS_BYTE) begin
            case (w[byte_op_pkg::OPC_MSB:byte_op_pkg::OPC_LSB])
                byte_op_pkg::OPC_DECREMENT: s = byte_op_pkg::DECREMENT_FILE_OP;
                byte_op_pkg::OPC_COMPLEMENT: s = byte_op_pkg::COMPLEMENT_FILE_OP;
                byte_op_pkg::OPC_DEC_SKIP: s = byte_op_pkg::DECREMENT_SKIP_ZERO_OP;
                byte_op_pkg::OPC_OR_WORKING: s = byte_op_pkg::OR_WORKING_WITH_FILE_OP;
                default: s = byte_op_pkg::NO_OP_SEL;
            endcase
        end
        return s;
    endfunction

    // registered outputs and their next values
    logic [ADDR_WIDTH-1:0] addr_q, addr_d;
    logic [DATA_WIDTH-1:0] wdata_q, wdata_d;
    logic we_q, we_d;
    logic [DATA_WIDTH-1:0] working_q, working_d;
    logic zero_q, zero_d;
    logic flush_q, flush_d;
    logic nop_q, nop_d;
    byte_op_pkg::op_sel_t op;
    logic dest_bit;
    logic [DATA_WIDTH-1:0] operand;
    logic [DATA_WIDTH-1:0] result;
    logic active;

    // operand fetch and arithmetic
    always_comb begin
        op = decode_op(instr_in);
        dest_bit = instr_in[byte_op_pkg::DEST_POS];
        // port pins read instead of latch
        operand = file_is_port_in ? port_pins_in : file_data_in;
        // a flushed slot must never act, so it is gated here
        active = instr_valid_in && !flush_q;
        // unknown words pass the operand through; nothing downstream acts on them
        case (op)
            byte_op_pkg::DECREMENT_FILE_OP: result = operand - 8'h01;
            byte_op_pkg::COMPLEMENT_FILE_OP: result = ~operand;
            byte_op_pkg::DECREMENT_SKIP_ZERO_OP: result = operand - 8'h01;
            byte_op_pkg::OR_WORKING_WITH_FILE_OP: result = working_q | operand;
            default: result = operand;
        endcase
    end

    // next state of destinations, flags and skip control
    always_comb begin
        // the address follows every word, so a write pulse always pairs with its own address
        addr_d = instr_in[ADDR_WIDTH-1:0];
        wdata_d = wdata_q;
        we_d = 1'b0;
        working_d = working_q;
        zero_d = zero_q;
        flush_d = 1'b0;
        nop_d = 1'b0;
        if (flush_q) begin
            nop_d = 1'b1;
        end else if (active && op != byte_op_pkg::NO_OP_SEL) begin
            if (dest_bit == byte_op_pkg::DEST_WORKING) begin
                working_d = result;
            end else begin
                wdata_d = result;
                we_d = 1'b1;
            end
            if (op == byte_op_pkg::DECREMENT_SKIP_ZERO_OP) begin
                // zero result drops next fetched word
                flush_d = (result == 8'h00);
            end else begin
                zero_d = (result == 8'h00);
            end
        end
    end

    // registered state, reset to quiet values
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            addr_q <= '0;
            wdata_q <= '0;
            we_q <= 1'b0;
            working_q <= byte_op_pkg::WORKING_RESET;
            zero_q <= byte_op_pkg::ZERO_RESET;
            flush_q <= 1'b0;
            nop_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            we_q <= we_d;
            working_q <= working_d;
            zero_q <= zero_d;
            flush_q <= flush_d;
            nop_q <= nop_d;
        end
    end

    // outputs come straight from the registers
    assign file_addr_out = addr_q;
    assign file_wdata_out = wdata_q;
    assign file_we_out = we_q;
    assign working_out = working_q;
    assign zero_flag_out = zero_q;
    assign flush_next_out = flush_q;
    assign nop_cycle_out = nop_q;

    // a taking skip: a live skip word whose operand is one, so the decrement lands on zero
    sequence s_skip_zero;
        instr_valid_in && !flush_q && op == byte_op_pkg::DECREMENT_SKIP_ZERO_OP && operand == 8'h01;
    endsequence

    chk_skip_flush: assert property (@(posedge clock_in) disable iff (rst_in)
        s_skip_zero |=> flush_q ##1 nop_q)
        else $error("zero skip did not flush next instruction");
    chk_flush_nop_slot: assert property (@(posedge clock_in) disable iff (rst_in)
        flush_q |=> nop_q && !we_q && $stable(working_q) && $stable(zero_q))
        else $error("flushed slot had an effect");
    chk_skip_flags_kept: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op == byte_op_pkg::DECREMENT_SKIP_ZERO_OP) |=> $stable(zero_q))
        else $error("skip changed zero flag");
    chk_no_skip_nonzero: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op == byte_op_pkg::DECREMENT_SKIP_ZERO_OP && operand != 8'h01) |=> !flush_q)
        else $error("nonzero skip result flushed");
    chk_dec_to_working: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op == byte_op_pkg::DECREMENT_FILE_OP && !dest_bit) |=>
        working_q == $past(operand) - 8'h01 && zero_q == ($past(operand) == 8'h01))
        else $error("decrement result wrong");
    chk_comp_result: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op == byte_op_pkg::COMPLEMENT_FILE_OP && dest_bit) |=>
        we_q && file_wdata_out == ~$past(operand))
        else $error("complement result wrong");
    chk_or_result: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op == byte_op_pkg::OR_WORKING_WITH_FILE_OP && !dest_bit) |=>
        working_q == ($past(working_q) | $past(operand)))
        else $error("or result wrong");
    chk_dest_file_only: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op != byte_op_pkg::NO_OP_SEL && dest_bit) |=>
        we_q && $stable(working_q) && file_addr_out == $past(instr_in[ADDR_WIDTH-1:0]))
        else $error("file destination misrouted");
    chk_dest_working_only: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op != byte_op_pkg::NO_OP_SEL && !dest_bit) |=> !we_q)
        else $error("working destination wrote file");
    chk_port_pins_used: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op == byte_op_pkg::COMPLEMENT_FILE_OP && dest_bit && file_is_port_in) |=>
        file_wdata_out == ~$past(port_pins_in))
        else $error("port read used latch value");

    // the two slots of a taking skip: the flush pulse, then the no-op pulse
    sequence s_flush_then_nop;
        flush_q ##1 (nop_q && !flush_q);
    endsequence

    // a taking skip costs exactly two slots, never a third
    chk_skip_two_slots: assert property (@(posedge clock_in) disable iff (rst_in)
        s_skip_zero |=> s_flush_then_nop ##1 !nop_q)
        else $error("taking skip did not last two slots");
    chk_nop_needs_flush: assert property (@(posedge clock_in) disable iff (rst_in)
        nop_q |-> $past(flush_q))
        else $error("no-op slot without a flush");
    chk_flush_single: assert property (@(posedge clock_in) disable iff (rst_in)
        flush_q |=> !flush_q)
        else $error("flush lasted more than one slot");
    chk_skip_dest_write: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && op == byte_op_pkg::DECREMENT_SKIP_ZERO_OP && dest_bit) |=>
        we_q && file_wdata_out == $past(operand) - 8'h01)
        else $error("skip did not write decremented value");
    chk_single_cycle_ops: assert property (@(posedge clock_in) disable iff (rst_in)
        (active && (op == byte_op_pkg::DECREMENT_FILE_OP || op == byte_op_pkg::COMPLEMENT_FILE_OP ||
        op == byte_op_pkg::OR_WORKING_WITH_FILE_OP)) |=> !flush_q && !nop_q)
        else $error("single-cycle op took an extra slot");
    chk_addr_follows: assert property (@(posedge clock_in) disable iff (rst_in)
        instr_valid_in |=> file_addr_out == $past(instr_in[ADDR_WIDTH-1:0]))
        else $error("file address not taken from word");
endmodule

//--- test_byte_op_decode_execute.sv
// self-checking bench for the byte-oriented decode and execute block
`timescale 1ns/1ns
module test_byte_op_decode_execute;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic instr_valid_in = 1'b0;
    logic [13:0] instr_in = 14'h0000;
    logic [7:0] file_data_in = 8'h00;
    logic file_is_port_in = 1'b0;
    logic [7:0] port_pins_in = 8'h00;
    logic [6:0] file_addr_out;
    logic [7:0] file_wdata_out, working_out;
    logic file_we_out, zero_flag_out, flush_next_out, nop_cycle_out;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;

    byte_op_decode_execute byte_op_decode_execute_inst (.clock_in(clock_in), .rst_in(rst_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .file_data_in(file_data_in),
        .file_is_port_in(file_is_port_in), .port_pins_in(port_pins_in), .file_addr_out(file_addr_out),
        .file_wdata_out(file_wdata_out), .file_we_out(file_we_out), .working_out(working_out),
        .zero_flag_out(zero_flag_out), .flush_next_out(flush_next_out), .nop_cycle_out(nop_cycle_out));

    // 25 MHz clock
    initial forever #20 clock_in = ~clock_in;

    // hang guard: the tests need well under a hundred cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            summarize();
        end
    end

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // pulse and flag outputs packed as we, zero, flush, nop so one compare covers them
    function automatic logic [7:0] flg();
        return {4'h0, file_we_out, zero_flag_out, flush_next_out, nop_cycle_out};
    endfunction

    // called at a falling edge; valid stays up so back-to-back words need no gap
    task go(input logic [3:0] opc, input logic d, input logic [6:0] f, input logic [7:0] data);
        instr_valid_in = 1'b1;
        instr_in = {byte_op_pkg::CLASS_BYTE, opc, d, f};
        file_data_in = data;
        @(negedge clock_in);
    endtask

    task idle(input string name);
        instr_valid_in = 1'b0;
        file_is_port_in = 1'b0;
        @(negedge clock_in);
        $display("test %s done", name);
    endtask

    task t_dec;
        go(byte_op_pkg::OPC_DECREMENT, 1'b0, 7'h05, 8'h01);
        chk(working_out, 8'h00, "dec w");
        chk(flg(), 8'h04, "dec flags");
        go(byte_op_pkg::OPC_DECREMENT, 1'b1, 7'h7f, 8'h00);
        chk(file_wdata_out, 8'hff, "dec wdata");
        chk(8'(file_addr_out), 8'h7f, "dec addr");
        chk(flg(), 8'h08, "dec we");
        chk(working_out, 8'h00, "dec w kept");
        idle("dec");
    endtask

    task t_com;
        go(byte_op_pkg::OPC_COMPLEMENT, 1'b0, 7'h00, 8'h13);
        chk(working_out, 8'hec, "com w");
        chk(flg(), 8'h00, "com flags");
        go(byte_op_pkg::OPC_COMPLEMENT, 1'b0, 7'h01, 8'hff);
        chk(working_out, 8'h00, "com zero");
        chk(flg(), 8'h04, "com z");
        // port source: latch reads all ones, pins carry another pattern
        file_is_port_in = 1'b1;
        port_pins_in = 8'h5a;
        go(byte_op_pkg::OPC_COMPLEMENT, 1'b1, 7'h06, 8'hff);
        chk(file_wdata_out, 8'ha5, "com port");
        chk(flg(), 8'h08, "com we");
        chk(working_out, 8'h00, "com w kept");
        port_pins_in = 8'h00;
        idle("com");
    endtask

    task t_or;
        go(byte_op_pkg::OPC_COMPLEMENT, 1'b0, 7'h02, 8'h6e);
        go(byte_op_pkg::OPC_OR_WORKING, 1'b0, 7'h0c, 8'h13);
        chk(working_out, 8'h93, "or w");
        chk(flg(), 8'h00, "or flags");
        // port source: latch reads all ones but the pins are low
        file_is_port_in = 1'b1;
        go(byte_op_pkg::OPC_OR_WORKING, 1'b1, 7'h06, 8'hff);
        chk(file_wdata_out, 8'h93, "or port");
        chk(flg(), 8'h08, "or we");
        idle("or");
    endtask

    task t_skip;
        go(byte_op_pkg::OPC_COMPLEMENT, 1'b0, 7'h03, 8'hff);
        go(byte_op_pkg::OPC_DEC_SKIP, 1'b1, 7'h05, 8'h01);
        chk(file_wdata_out, 8'h00, "skip wdata");
        chk(flg(), 8'h0e, "skip flush");
        go(byte_op_pkg::OPC_DECREMENT, 1'b0, 7'h05, 8'h10);
        chk(flg(), 8'h05, "skip nop");
        chk(working_out, 8'h00, "dropped word");
        go(byte_op_pkg::OPC_DEC_SKIP, 1'b0, 7'h06, 8'h03);
        chk(working_out, 8'h02, "noskip w");
        chk(flg(), 8'h04, "noskip flags");
        idle("skip");
    endtask

    // foreign opcode, foreign class and idle words change nothing; then a reset in mid-run
    task t_other;
        go(byte_op_pkg::OPC_COMPLEMENT, 1'b0, 7'h04, 8'h5a);
        chk(working_out, 8'ha5, "other setup");
        go(4'h8, 1'b1, 7'h04, 8'h00);
        chk(flg(), 8'h00, "other opcode");
        chk(working_out, 8'ha5, "other opcode w");
        instr_in = {2'h1, byte_op_pkg::OPC_DECREMENT, 1'b0, 7'h04};
        @(negedge clock_in);
        chk(working_out, 8'ha5, "other class");
        instr_valid_in = 1'b0;
        instr_in = {byte_op_pkg::CLASS_BYTE, byte_op_pkg::OPC_DECREMENT, 1'b0, 7'h04};
        @(negedge clock_in);
        chk(working_out, 8'ha5, "not valid");
        go(byte_op_pkg::OPC_DECREMENT, 1'b1, 7'h04, 8'h01);
        chk(flg(), 8'h0c, "pre reset flags");
        // a word offered during reset must not survive it
        rst_in = 1'b1;
        go(byte_op_pkg::OPC_DECREMENT, 1'b0, 7'h04, 8'h10);
        chk(working_out, 8'h00, "mid reset w");
        chk(flg(), 8'h00, "mid reset flags");
        rst_in = 1'b0;
        go(byte_op_pkg::OPC_DECREMENT, 1'b1, 7'h0a, 8'h03);
        chk(file_wdata_out, 8'h02, "first after reset");
        chk(8'(file_addr_out), 8'h0a, "first addr");
        chk(flg(), 8'h08, "first flags");
        idle("other");
    endtask

    // reset, then each scenario in turn
    initial begin
        repeat (20) @(negedge clock_in);
        rst_in = 1'b0;
        chk(working_out, 8'h00, "reset w");
        chk(flg(), 8'h00, "reset flags");
        t_dec();
        t_com();
        t_or();
        t_skip();
        t_other();
        summarize();
    end
endmodule
